// File: rtl/tsw_dev_end.sv
// tsw_dev_end: device end of the switch host port and serial stream control
// assumes host port signals come from logic on i_sys_clk; serial pins,
// master clock, frame pulse and drive enable come from outside and are
// synchronised here
// What this block does
// - streams carry data at 2.048 Mb/s
// - 4.096 MHz master clock shifts stream bits
// - frame pulse convention detected automatically
// - reset clears control register, port sequencer and frame lock, keeps memories, floats outputs
// - host holds reset low 100ns minimum
// - access only with strobe and select low
// - direction input sets data driver enable
// - chip select inactive ignores host port inputs except device reset
// - twelve-bit address maps memories and control
// - sixteen-bit two-way host data bus
// - acknowledge driven low when transfer completes
// - acknowledge driven high briefly, then released
// - drive enable and standby low float outputs
// - drive enable high; per-channel float still applies
`timescale 1ns/100ps
module tsw_dev_end
    import tsw_pkg::*;
(
    // clock and reset
    input  wire logic               i_sys_clk,
    input  wire logic               i_srst,
    // host port
    tsw_host_if.dev                 hp,
    // serial stream pins
    input  wire logic [STREAMS-1:0] i_serial_in_streams,
    output logic      [STREAMS-1:0] o_serial_out_streams,
    output logic      [STREAMS-1:0] o_serial_out_streams_oe,
    // framing and master drive enable
    input  wire logic               i_mclk,
    input  wire logic               i_frame_pulse_in,
    input  wire logic               i_output_drive_master_enable,
    // status
    output logic                    o_frame_fmt_high,
    output logic                    o_frame_locked
);

    ////////////////////////////////////////////////////////////////////////
    // address decode, shared by the write and read paths
    function automatic logic [1:0] addr_region(
        input logic [ADDR_W-1:0] a
    );
        addr_region = a[ADDR_W-1:ADDR_W-2];
    endfunction : addr_region

    localparam int SYNC_W = STREAMS + 3;

    logic [SYNC_W-1:0]  sy1_r;
    logic [SYNC_W-1:0]  sy2_r;
    logic [SYNC_W-1:0]  sy3_r;
    logic [SYNC_W-1:0]  syf_r;
    logic               rst_int;
    logic               mclk_d_r;
    logic               mclk_f;
    logic               fp_f;
    logic               ode_f;
    logic [STREAMS-1:0] rx_f;
    logic               bnd_edge;
    logic               smp_edge;
    logic               frame_act;
    logic               fp_d_r;
    logic [FP_CNT_W-1:0] run_r;
    logic               fmt_r;
    logic               locked_r;
    logic [POS_W-1:0]   pos_r;
    logic [POS_W-1:0]   pos_nxt;
    logic [DATA_W-1:0]  cr_r;
    logic               master_en;
    tsw_dp_state_type   dp_r;
    logic               sel;
    logic               rd_r;
    logic [DATA_W-1:0]  rdata_r;
    logic [DATA_W-1:0]  cmem [0:STREAMS-1][0:CHANS-1];
    logic [BYTE_W-1:0]  dmem [0:STREAMS-1][0:CHANS-1];
    logic [BYTE_W-1:0]  rxsh_r [0:STREAMS-1];

    assign rst_int = i_srst | ~hp.dev_rst_n;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a change counts once stages two and three agree
    always_ff @(posedge i_sys_clk) begin
        sy1_r <= {i_serial_in_streams, i_mclk, i_frame_pulse_in,
                  i_output_drive_master_enable};
        sy2_r <= sy1_r;
        sy3_r <= sy2_r;
        syf_r <= (sy2_r & sy3_r) | (syf_r & (sy2_r ^ sy3_r));
    end

    assign rx_f   = syf_r[SYNC_W-1:3];
    assign mclk_f = syf_r[2];
    assign fp_f   = syf_r[1];
    assign ode_f  = syf_r[0];

    ////////////////////////////////////////////////////////////////////////
    // frame pulse convention: the level whose run is short is the pulse
    always_ff @(posedge i_sys_clk) begin
        fp_d_r <= fp_f;
        if (rst_int) begin
            // start saturated: the run cut by reset has no known start,
            // so it must never be taken for a short pulse
            run_r    <= '1;
            fmt_r    <= 1'b0;
            locked_r <= 1'b0;
        end else if (fp_f != fp_d_r) begin
            if (run_r <= FP_CNT_W'(FP_MAX_CYC)) begin
                fmt_r    <= fp_d_r;
                locked_r <= 1'b1;
            end
            run_r <= '0;
        end else if (run_r != '1) begin
            run_r <= run_r + 1'b1;
        end
    end

    assign frame_act = locked_r & (fp_f == fmt_r);

    ////////////////////////////////////////////////////////////////////////
    // master clock edges: bit boundary on one edge, sampling on the other
    always_ff @(posedge i_sys_clk) begin
        mclk_d_r <= mclk_f;
    end

    assign bnd_edge = locked_r & (fmt_r ? (mclk_f & ~mclk_d_r)
                                        : (~mclk_f & mclk_d_r));
    assign smp_edge = locked_r & (fmt_r ? (~mclk_f & mclk_d_r)
                                        : (mclk_f & ~mclk_d_r));

    assign pos_nxt = frame_act ? '0 : pos_r + 1'b1;

    // frame position in master clock periods
    always_ff @(posedge i_sys_clk) begin
        if (rst_int) begin
            pos_r <= '0;
        end else if (bnd_edge) begin
            pos_r <= pos_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial outputs: byte low half of connection memory, msb first
    assign master_en = ode_f | cr_r[CR_OSB_BIT];

    always_ff @(posedge i_sys_clk) begin
        if (rst_int) begin
            o_serial_out_streams    <= '0;
            o_serial_out_streams_oe <= '0;
        end else if (bnd_edge && !pos_nxt[0]) begin
            for (int s = 0; s < STREAMS; s++) begin
                o_serial_out_streams[s] <=
                    cmem[s][pos_nxt[8:4]][~pos_nxt[3:1]];
                o_serial_out_streams_oe[s] <= master_en &
                    cmem[s][pos_nxt[8:4]][CM_OE_BIT];
            end
        end else if (!master_en) begin
            o_serial_out_streams_oe <= '0;
        end
    end

    // serial inputs sampled late in the bit, stored once per channel
    always_ff @(posedge i_sys_clk) begin
        if (smp_edge && pos_r[0]) begin
            for (int s = 0; s < STREAMS; s++) begin
                rxsh_r[s] <= {rxsh_r[s][BYTE_W-2:0], rx_f[s]};
                if (pos_r[3:1] == 3'h7) begin
                    dmem[s][pos_r[8:4]] <= {rxsh_r[s][BYTE_W-2:0], rx_f[s]};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host port sequencer
    // strobe and select both low
    assign sel = ~hp.cs_n & ~hp.strobe_n;

    always_ff @(posedge i_sys_clk) begin
        if (rst_int) begin
            dp_r <= DP_IDLE;
            rd_r <= 1'b0;
        end else begin
            case (dp_r)
                DP_IDLE: begin
                    if (sel) begin
                        dp_r <= DP_ACK;
                        rd_r <= (hp.rw == RW_READ);
                    end
                end
                DP_ACK: begin
                    if (!sel) begin
                        dp_r <= DP_REL;
                    end
                end
                DP_REL: begin
                    dp_r <= DP_IDLE;
                    rd_r <= 1'b0;
                end
                default: begin
                    dp_r <= DP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (rst_int) begin
            cr_r <= CR_RESET;
        end else if (dp_r == DP_IDLE && sel && hp.rw != RW_READ) begin
            if (addr_region(hp.host_addr) == REG_CM) begin
                cmem[hp.host_addr[9:5]][hp.host_addr[4:0]] <= hp.host_bus;
            end else if (hp.host_addr == CR_ADDR) begin
                cr_r <= hp.host_bus;
            end
        end
    end

    // read data captured when the access is taken; unmapped reads zero
    always_ff @(posedge i_sys_clk) begin
        if (rst_int) begin
            rdata_r <= '0;
        end else if (dp_r == DP_IDLE && sel) begin
            case (addr_region(hp.host_addr))
                REG_CM:  rdata_r <= cmem[hp.host_addr[9:5]][hp.host_addr[4:0]];
                REG_DM:  rdata_r <= {8'h00,
                    dmem[hp.host_addr[9:5]][hp.host_addr[4:0]]};
                REG_CR:  rdata_r <= (hp.host_addr == CR_ADDR) ? cr_r : '0;
                default: rdata_r <= '0;
            endcase
        end
    end

    assign hp.bus_d    = rdata_r;
    assign hp.bus_d_oe = (dp_r == DP_ACK) & rd_r;

    // low while acked, high one cycle
    assign hp.ack_n_o  = (dp_r != DP_ACK);
    assign hp.ack_n_oe = (dp_r == DP_ACK) | (dp_r == DP_REL);

    assign o_frame_fmt_high = fmt_r;
    assign o_frame_locked   = locked_r;

endmodule : tsw_dev_end

// File: rtl/tsw_pkg.sv
// tsw_pkg: shared constants and state types for the switch host port
// assumes a single 40 MHz system clock on both ends of the host port
package tsw_pkg;

    // stream geometry and bus widths
    localparam int STREAMS   = 32;
    localparam int CHANS     = 32;
    localparam int BYTE_W    = 8;
    localparam int ADDR_W    = 12;
    localparam int DATA_W    = 16;
    localparam int POS_W     = 9;

    // rates and times in their own units
    localparam int SYS_PERIOD_NS    = 25;
    localparam int SERIAL_RATE_KBPS = 2048;
    localparam int MCLK_KHZ         = 4096;
    localparam int MCLK_PERIOD_NS   = 1000000 / MCLK_KHZ;
    localparam int TICKS_PER_BIT    = MCLK_KHZ / SERIAL_RATE_KBPS;
    localparam int RST_MIN_NS       = 100;
    localparam int FP_MAX_NS        = TICKS_PER_BIT * MCLK_PERIOD_NS;

    // derived cycle counts (least time rounds up, longest rounds down)
    localparam int RST_MIN_CYC =
        (RST_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int FP_MAX_CYC  = FP_MAX_NS / SYS_PERIOD_NS;
    localparam int FP_CNT_W    = 5;

    // address map: region in the top two address bits
    localparam logic [1:0]        REG_CM    = 2'h0;
    localparam logic [1:0]        REG_DM    = 2'h1;
    localparam logic [1:0]        REG_CR    = 2'h2;
    localparam logic [ADDR_W-1:0] CM_BASE   = 12'h000;
    localparam logic [ADDR_W-1:0] DM_BASE   = 12'h400;
    localparam logic [ADDR_W-1:0] CR_ADDR   = 12'h800;

    // field positions and reset values
    localparam int                CR_OSB_BIT = 2;
    localparam int                CM_OE_BIT  = 14;
    localparam logic [DATA_W-1:0] CR_RESET   = 16'h0000;
    localparam logic [DATA_W-1:0] BUS_PULL   = 16'hFFFF;
    localparam logic              RW_READ    = 1'b1;

    // device-side port sequencer
    typedef enum logic [1:0] {
        DP_IDLE,
        DP_ACK,
        DP_REL
    } tsw_dp_state_type;

    // host-side access sequencer
    typedef enum logic [1:0] {
        HP_IDLE,
        HP_WAIT,
        HP_GAP,
        HP_RST
    } tsw_hp_state_type;

endpackage : tsw_pkg

// File: rtl/tsw_host_if.sv
// tsw_host_if: the microprocessor port wires between host and device
// assumes open pins are resolved here from each end's output enables
`timescale 1ns/100ps
interface tsw_host_if;
    import tsw_pkg::*;

    logic              cs_n;
    logic              strobe_n;
    logic              rw;
    logic [ADDR_W-1:0] host_addr;
    logic              dev_rst_n;
    logic [DATA_W-1:0] bus_h;
    logic              bus_h_oe;
    logic [DATA_W-1:0] bus_d;
    logic              bus_d_oe;
    logic [DATA_W-1:0] host_bus;
    logic              ack_n_o;
    logic              ack_n_oe;
    logic              ack_n;

    // wire levels; undriven lines float to the pull-up level
    assign host_bus = bus_d_oe ? bus_d : (bus_h_oe ? bus_h : BUS_PULL);
    assign ack_n    = ack_n_oe ? ack_n_o : 1'b1;

    modport dev (
        input  cs_n, strobe_n, rw, host_addr, dev_rst_n, host_bus,
        output bus_d, bus_d_oe, ack_n_o, ack_n_oe
    );

    modport host (
        output cs_n, strobe_n, rw, host_addr, dev_rst_n, bus_h, bus_h_oe,
        input  host_bus, ack_n
    );

endinterface : tsw_host_if

// File: rtl/tsw_host_end.sv
// tsw_host_end: microprocessor end of the switch host port
// assumes the device runs on the same i_sys_clk and answers with ack
`timescale 1ns/100ps
module tsw_host_end
    import tsw_pkg::*;
(
    // clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_srst,
    // host port
    tsw_host_if.host               hp,
    // user request
    input  wire logic              i_req,
    input  wire logic              i_wr,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_dev_rst_req,
    // user answer
    output logic      [DATA_W-1:0] o_rdata,
    output logic                   o_done,
    output logic                   o_busy
);

    tsw_hp_state_type  st_r;
    logic              wr_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [2:0]        rcnt_r;

    ////////////////////////////////////////////////////////////////////////
    // access sequencer; a gap cycle lets the device finish releasing ack
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            st_r   <= HP_IDLE;
            rcnt_r <= '0;
        end else begin
            case (st_r)
                HP_IDLE: begin
                    if (i_dev_rst_req) begin
                        st_r   <= HP_RST;
                        rcnt_r <= 3'(RST_MIN_CYC - 1);
                    end else if (i_req) begin
                        st_r <= HP_WAIT;
                    end
                end
                HP_WAIT: begin
                    if (!hp.ack_n) begin
                        st_r <= HP_GAP;
                    end
                end
                HP_GAP: begin
                    st_r <= HP_IDLE;
                end
                HP_RST: begin
                    if (rcnt_r == '0) begin
                        st_r <= HP_IDLE;
                    end else begin
                        rcnt_r <= rcnt_r - 1'b1;
                    end
                end
                default: begin
                    st_r <= HP_IDLE;
                end
            endcase
        end
    end

    // request fields latched when taken
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            wr_r    <= 1'b0;
            addr_r  <= '0;
            wdata_r <= '0;
        end else if (st_r == HP_IDLE && i_req && !i_dev_rst_req) begin
            wr_r    <= i_wr;
            addr_r  <= i_addr;
            wdata_r <= i_wdata;
        end
    end

    // read data and completion pulse
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_rdata <= '0;
            o_done  <= 1'b0;
        end else begin
            o_done <= (st_r == HP_WAIT) & ~hp.ack_n;
            if (st_r == HP_WAIT && !hp.ack_n && !wr_r) begin
                o_rdata <= hp.host_bus;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive
    // both strobes during access
    assign hp.cs_n      = (st_r != HP_WAIT);
    assign hp.strobe_n  = (st_r != HP_WAIT);
    assign hp.rw        = ~wr_r;
    assign hp.host_addr = addr_r;
    assign hp.bus_h     = wdata_r;
    assign hp.bus_h_oe  = (st_r == HP_WAIT) & wr_r;
    assign hp.dev_rst_n = (st_r != HP_RST);
    assign o_busy       = (st_r != HP_IDLE);

endmodule : tsw_host_end

// File: testbench/tsw_assertions.sv
// tsw_assertions: timing checks on the host port wires
// assumes it sits beside the interface joining host end and device end
`timescale 1ns/100ps
module tsw_assertions
    import tsw_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // host port wires
    input wire logic cs_n,
    input wire logic strobe_n,
    input wire logic rw,
    input wire logic dev_rst_n,
    input wire logic bus_d_oe,
    input wire logic ack_n_oe,
    input wire logic ack_n
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
////////////////////////////////////////////////////////////
    a_reset_float: assert property (
            !dev_rst_n |=> !bus_d_oe && !ack_n_oe)
        else $error("port driven during device reset");
    a_reset_hold: assert property (
            $fell(dev_rst_n) |-> !dev_rst_n [*4])
        else $error("device reset too short");
    a_ack_answer: assert property (
            !cs_n && !strobe_n && $past(cs_n) && dev_rst_n |=> !ack_n)
        else $error("no acknowledge one cycle after select");
    a_ack_cause: assert property (
            $fell(ack_n) |-> !$past(cs_n) && !$past(strobe_n))
        else $error("acknowledge without select and strobe");
    a_idle_quiet: assert property (
            cs_n [*3] |-> !ack_n_oe && !bus_d_oe)
        else $error("port active while deselected");
    a_read_drive: assert property (
            $rose(ack_n_oe) |-> bus_d_oe == rw)
        else $error("data drive does not follow direction");
    a_data_in_ack: assert property (
            bus_d_oe |-> ack_n_oe && !ack_n)
        else $error("read data driven outside acknowledge");
    a_ack_release: assert property (
            $rose(cs_n) && !ack_n |=> ack_n && ack_n_oe ##1 !ack_n_oe)
        else $error("acknowledge not driven high then released");
    a_one_ack: assert property (
            $rose(ack_n) |=> ack_n [*2])
        else $error("acknowledge repeated within access");
endmodule : tsw_assertions

// File: testbench/tb.sv
// tb: drives the host end user side and the device serial pins
// assumes both ends share i_sys_clk and face each other over tsw_host_if
`timescale 1ns/100ps
module tb;
    import tsw_pkg::*;
    logic               i_sys_clk, i_srst, i_req, i_wr, i_dev_rst_req;
    logic               output_drive_master_enable, fp_high, mclk, act, fp;
    logic               o_done, o_busy, o_frame_fmt_high, o_frame_locked;
    logic [ADDR_W-1:0]  i_addr;
    logic [DATA_W-1:0]  i_wdata, o_rdata;
    logic [STREAMS-1:0] sin, sout, soe;
    logic [DATA_W-1:0]  exp_q[$];
    bit                 rd_q[$];
    int                 errors, checks_done, seed, rst_run, h, n;
    tsw_host_if hp();
    tsw_dev_end tsw_dev_end_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
        .hp(hp.dev), .i_serial_in_streams(sin), .o_serial_out_streams(sout),
        .o_serial_out_streams_oe(soe), .i_mclk(mclk), .i_frame_pulse_in(fp),
        .i_output_drive_master_enable(output_drive_master_enable),
        .o_frame_fmt_high(o_frame_fmt_high), .o_frame_locked(o_frame_locked));
    tsw_host_end tsw_host_end_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
        .hp(hp.host), .i_req(i_req), .i_wr(i_wr), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_dev_rst_req(i_dev_rst_req), .o_rdata(o_rdata),
        .o_done(o_done), .o_busy(o_busy));
    tsw_assertions tsw_assertions_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
        .cs_n(hp.cs_n), .strobe_n(hp.strobe_n), .rw(hp.rw),
        .dev_rst_n(hp.dev_rst_n), .bus_d_oe(hp.bus_d_oe),
        .ack_n_oe(hp.ack_n_oe), .ack_n(hp.ack_n));
////////////////////////////////////////////////////////////
    // clocks; master clock is free running and unrelated to i_sys_clk
    initial begin
        i_sys_clk = 0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        h = 0;
        forever #122 h = (h + 1) % 1024;
    end
    // frame pulse straddles the boundary edge of its convention
    assign mclk = h[0];
    assign act  = fp_high ? (h == 2 || h == 3) : (h == 1 || h == 2);
    assign fp   = act ? fp_high : ~fp_high;
    always @(posedge i_sys_clk) sin <= #1 $random(seed);
    task automatic results();
        if (errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    // wide enough for the packed reset checks of bus enables and streams
    task automatic chk(input string nm, input logic [63:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            errors++;
        end
    endtask : chk
    // bounded wait until the host end is idle
    task automatic idle();
        n = 0;
        while (o_busy !== 1'b0 && n < 30) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        if (n == 30) begin
            errors++;
            results();
        end
    endtask : idle
    task automatic acc(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, e);
        idle();
        @(posedge i_sys_clk);
        #1;
        i_req = 1;
        i_wr = wr;
        i_addr = a;
        i_wdata = d;
        exp_q.push_back(e);
        rd_q.push_back(!wr);
        @(posedge i_sys_clk);
        #1;
        i_req = 0;
        idle();
    endtask : acc
    // longest enable run of stream 5 in one frame; off means all floated
    // bit k of the channel is sampled near its middle, at run 20k+11
    task automatic watch(input logic on);
        int run, best, bad;
        logic [7:0] sh, pat;
        run = 0;
        best = 0;
        bad = 0;
        sh = '0;
        pat = '0;
        repeat (5200) begin
            @(posedge i_sys_clk);
            #1;
            if (!on && soe !== '0) bad = 1;
            if (soe[5] === 1'b1) run++;
            else run = 0;
            if (run > best) best = run;
            if (run % 20 == 11) sh = {sh[6:0], sout[5]};
            if (run == 151) pat = sh;
        end
        if (on) chk("chan_len", 32'(best >= 154 && best <= 158), 1);
        if (on) chk("chan_data", pat, 8'hA5);
        if (!on) chk("soe_off", bad, 0);
    endtask : watch
    task automatic lock(input logic fmt);
        n = 0;
        while (o_frame_locked !== 1'b1 && n < 12000) begin
            @(posedge i_sys_clk);
            n++;
        end
        chk("locked", o_frame_locked, 1);
        chk("fmt_high", o_frame_fmt_high, fmt);
        // a lock that never came is already counted; stop here
        if (o_frame_locked !== 1'b1) results();
    endtask : lock
////////////////////////////////////////////////////////////
    // result watcher: pops the oldest note on every completion
    always begin
        @(posedge i_sys_clk);
        #2;
        if (o_done === 1'b1) begin
            if (exp_q.size() == 0) chk("done", 1, 0);
            else if (rd_q.pop_front())
                chk("rdata", o_rdata, exp_q.pop_front());
            else void'(exp_q.pop_front());
        end
        if (hp.ack_n === 1'b0 && hp.ack_n_oe === 1'b1 && n >= 0)
            if (hp.rw === 1'b0) chk("wr_float", hp.bus_d_oe, 0);
        if (hp.dev_rst_n === 1'b0) begin
            rst_run++;
            if (rst_run > 1) chk("rst_float", {hp.bus_d_oe, soe}, 0);
        end else if (rst_run > 0) begin
            chk("rst_len", rst_run, RST_MIN_CYC);
            rst_run = 0;
        end
    end
    initial begin
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        seed = 32'h60AA0028;
        {errors, checks_done, rst_run} = '0;
        {i_srst, i_req, i_wr, i_dev_rst_req, output_drive_master_enable, fp_high} = 6'h20;
        {i_addr, i_wdata} = '0;
        repeat (4) @(posedge i_sys_clk);
        #1;
        chk("reset_float", {hp.ack_n, hp.bus_d_oe, soe},
            34'h200000000);
        i_srst = 0;
        acc(0, CR_ADDR, 0, CR_RESET);
        // random round trips through connection memory, no channel enabled
        repeat (6) begin
            a = $random(seed) & 12'h3FF;
            d = $random(seed) & 16'hBFFF;
            acc(1, a, d, 0);
            acc(0, a, 0, d);
        end
        acc(1, 12'hC00, 16'h1234, 0);
        acc(0, 12'hC00, 0, 16'h0000);
        // stream 5: only channel 10 drives, its neighbours float
        for (int c = 9; c < 12; c++)
            acc(1, 12'(5 * 32 + c), (c == 10) ? 16'h40A5 : 16'h0000, 0);
        acc(0, 12'h0AA, 0, 16'h40A5);
        lock(0);
        watch(0);
        output_drive_master_enable = 1;
        watch(1);
        output_drive_master_enable = 0;
        acc(1, CR_ADDR, 16'h0004, 0);
        acc(0, CR_ADDR, 0, 16'h0004);
        watch(1);
        // device reset clears the control register; swap convention
        fp_high = 1;
        @(posedge i_sys_clk);
        #1 i_dev_rst_req = 1;
        @(posedge i_sys_clk);
        #1 i_dev_rst_req = 0;
        repeat (10) @(posedge i_sys_clk);
        acc(0, CR_ADDR, 0, CR_RESET);
        lock(1);
        chk("queue_left", exp_q.size(), 0);
        results();
    end
endmodule : tb
